// >>> rtl/isa_extension_execute_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Trap every 64-bit data request, integer or coprocessor, in any mode.
// RQ2: Decode move_if_nonzero: base opcode, function 001011, bits 10:6 zero.
// RQ3: move_if_nonzero writes source to destination only when test is nonzero.
// RQ4: Decode move_if_zero: base opcode, function 001010, same fields.
// RQ5: move_if_zero writes source to destination only when test is zero.
// RQ6: Signed multiply added to accumulator, never overflow.
// RQ7: Unsigned zero-extended multiply added to accumulator, no overflow.
// RQ8: Signed multiply subtracted from accumulator, never overflow.
// RQ9: Unsigned multiply subtracted from accumulator, no overflow.
// RQ10: Result bits 31..0 go to bottom word, 63..32 to upper word.
// RQ11: Accumulator reads are not stalled while busy; issuer must wait.
// RQ12: Count leading zero bits of source, write count to target.
// RQ13: Source with no set bits gives count 32.
// RQ14: Count leading one bits of source, write count to target.
// RQ15: Source all ones gives count 32.
// RQ16: Three-operand multiply writes product straight to a general register.
// RQ17: Accumulate and subtract wrap modulo two to the sixty-fourth.
// RQ18: Unassigned encodings raise reserved-instruction exception.
module isa_extension_execute_unit
   import isa_ext_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           rstn,
   input  wire isa_ext_pkg::ext_req_t          req,
   output logic                                req_ready_ff,
   output isa_ext_pkg::ext_rsp_t               rsp_ff,
   output logic      [isa_ext_pkg::DATA_W-1:0] upper_acc_word_ff,
   output logic      [isa_ext_pkg::DATA_W-1:0] bottom_acc_word_ff,
   output logic                                acc_busy_ff,
   output logic                                acc_done_ff
);
   import isa_ext_pkg::*;

   logic [5:0]        opcode;
   logic [5:0]        funct;
   logic [REG_W-1:0]  tst_field;
   logic [REG_W-1:0]  dst_field;
   logic [4:0]        shf_field;
   logic [9:0]        low_ten;
   ext_op_t           op;
   logic              base_assigned;
   logic              grp_assigned;
   logic              prim_assigned;
   logic              take;
   logic              acc_take;

   logic [CNT_W-1:0]  lead_count;
   logic              count_ones;

   logic [ACC_W-1:0]  prod_signed;
   logic [ACC_W-1:0]  prod_unsigned;
   logic [ACC_W-1:0]  prod_ff;
   logic              sub_ff;
   logic [ACC_W-1:0]  acc_now;
   logic [ACC_W-1:0]  nxt_acc;
   acc_state_t        acc_state_ff;
   ext_rsp_t          nxt_rsp;

   assign opcode    = req.instr[OPC_HI:OPC_LO];
   assign funct     = req.instr[FUN_HI:FUN_LO];
   assign tst_field = req.instr[TST_HI:TST_LO];
   assign dst_field = req.instr[DST_HI:DST_LO];
   assign shf_field = req.instr[SHF_HI:SHF_LO];
   // Must be zero for the accumulate and count operations
   assign low_ten   = req.instr[DST_HI:SHF_LO];

   assign prim_assigned = PRIMARY_MAP[opcode];
   assign base_assigned = BASEFN_MAP[funct];
   assign grp_assigned  = GROUP28_MAP[funct];

   assign take = req.valid & req_ready_ff;

   // Decode; the wide trap outranks every other outcome
   always_comb begin
      op = op_none;
      if (req.wide_request) begin
         // RQ1: wide data trap
         op = op_wide;
      end else if (!prim_assigned) begin
         // RQ18: unassigned primary
         op = op_reserved;
      end else if (opcode == OPC_BASE_FUNC) begin
         // Other assigned base functions stay op_none: the main pipeline runs them
         if (!base_assigned) begin
            // RQ18: unassigned base function
            op = op_reserved;
         end else if (funct == FN_MOVE_IF_NONZERO) begin
            // RQ2: move_if_nonzero decode
            op = (shf_field == ZERO5) ? op_move_if_nonzero : op_reserved;
         end else if (funct == FN_MOVE_IF_ZERO) begin
            // RQ4: move_if_zero decode
            op = (shf_field == ZERO5) ? op_move_if_zero : op_reserved;
         end
      end else if (opcode == OPC_GROUP28) begin
         if (!grp_assigned) begin
            // RQ18: unassigned group function
            op = op_reserved;
         end else begin
            unique case (funct)
               FN_MAC_SIGNED: begin
                  // RQ6: signed accumulate decode
                  op = (low_ten == ZERO10) ? op_multiply_accumulate_signed
                                           : op_reserved;
               end
               FN_MAC_UNSIGNED: begin
                  // RQ7: unsigned accumulate decode
                  op = (low_ten == ZERO10) ? op_multiply_accumulate_unsigned
                                           : op_reserved;
               end
               FN_MULTIPLY_SUBTRACT_SIGNED_SIGNED: begin
                  // RQ8: signed subtract decode
                  op = (low_ten == ZERO10) ? op_multiply_subtract_signed
                                           : op_reserved;
               end
               FN_MULTIPLY_SUBTRACT_SIGNED_UNSIGNED: begin
                  // RQ9: unsigned subtract decode
                  op = (low_ten == ZERO10) ? op_multiply_subtract_unsigned
                                           : op_reserved;
               end
               FN_THREE_OP_MUL: begin
                  // RQ16: three-operand multiply decode
                  op = (shf_field == ZERO5) ? op_three_operand_multiply
                                            : op_reserved;
               end
               FN_COUNT_ZEROS: begin
                  // RQ12: leading zero count decode
                  op = (low_ten == ZERO10) ? op_count_leading_zero_bits
                                           : op_reserved;
               end
               FN_COUNT_ONES: begin
                  // RQ14: leading one count decode
                  op = (low_ten == ZERO10) ? op_count_leading_one_bits
                                           : op_reserved;
               end
               default: begin
                  op = op_reserved;
               end
            endcase
         end
      end
   end

   assign count_ones = (op == op_count_leading_one_bits);

   // Fed every cycle; only the two count operations use the result
   // RQ13: all-clear source counts 32
   // RQ15: all-set source counts 32
   leading_bit_counter u_lead (
      .value      (req.operand_a_reg),
      .count_ones (count_ones),
      .count      (lead_count)
   );

   // RQ6: two's complement operands sign-extended
   // RQ8: same signed product feeds subtract
   assign prod_signed = {{DATA_W{req.operand_a_reg[DATA_W-1]}}, req.operand_a_reg}
                      * {{DATA_W{req.operand_b_reg[DATA_W-1]}}, req.operand_b_reg};

   // RQ7: zero-extended operands
   // RQ9: same unsigned product feeds subtract
   assign prod_unsigned = {ZERO32, req.operand_a_reg} * {ZERO32, req.operand_b_reg};

   // Result for the single-cycle operations
   always_comb begin
      nxt_rsp               = '0;
      nxt_rsp.valid         = take;
      nxt_rsp.dest          = dst_field;
      nxt_rsp.data          = req.operand_a_reg;
      unique case (op)
         op_none: begin
            // Not ours and not a trap, so the pipeline keeps it
            nxt_rsp.claimed = 1'b0;
         end
         op_move_if_nonzero: begin
            nxt_rsp.claimed = 1'b1;
            // RQ3: write only on nonzero test
            nxt_rsp.write   = (req.operand_b_reg != ZERO32);
         end
         op_move_if_zero: begin
            nxt_rsp.claimed = 1'b1;
            // RQ5: write only on zero test
            nxt_rsp.write   = (req.operand_b_reg == ZERO32);
         end
         op_multiply_accumulate_signed,
         op_multiply_accumulate_unsigned,
         op_multiply_subtract_signed,
         op_multiply_subtract_unsigned: begin
            // No overflow trap on any accumulator operation
            nxt_rsp.claimed = 1'b1;
         end
         op_three_operand_multiply: begin
            nxt_rsp.claimed = 1'b1;
            nxt_rsp.write   = 1'b1;
            // Upper product word is dropped; accumulator left alone
            // RQ16: low product word to register
            nxt_rsp.data    = prod_signed[DATA_W-1:0];
         end
         op_count_leading_zero_bits,
         op_count_leading_one_bits: begin
            nxt_rsp.claimed = 1'b1;
            nxt_rsp.write   = 1'b1;
            nxt_rsp.dest    = tst_field;
            // RQ12: count lands in target
            // RQ14: count lands in target
            nxt_rsp.data    = {{(DATA_W-CNT_W){1'b0}}, lead_count};
         end
         op_reserved: begin
            nxt_rsp.claimed       = 1'b1;
            // RQ18: reserved-instruction exception
            nxt_rsp.reserved_trap = 1'b1;
         end
         op_wide: begin
            nxt_rsp.claimed   = 1'b1;
            // RQ1: trap raised, no write
            nxt_rsp.wide_trap = 1'b1;
         end
      endcase
      // Idle cycles show a cleared response rather than stale decode
      if (!take) begin
         nxt_rsp = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   // Multiply stage: product captured, then folded in next cycle
   // Registering the product keeps the 64-bit adder off the multiplier path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prod_ff <= ACC_RST;
      end else if (take) begin
         unique case (op)
            op_multiply_accumulate_signed: begin
               prod_ff <= prod_signed;
            end
            op_multiply_accumulate_unsigned: begin
               prod_ff <= prod_unsigned;
            end
            op_multiply_subtract_signed: begin
               prod_ff <= prod_signed;
            end
            op_multiply_subtract_unsigned: begin
               prod_ff <= prod_unsigned;
            end
            default: begin
               prod_ff <= prod_ff;
            end
         endcase
      end
   end

   function automatic logic is_acc_op(input ext_op_t o);
      is_acc_op = (o == op_multiply_accumulate_signed)
                | (o == op_multiply_accumulate_unsigned)
                | (o == op_multiply_subtract_signed)
                | (o == op_multiply_subtract_unsigned);
   endfunction

   // One term for every place except the product register that reacts to an accepted accumulate
   assign acc_take = take & is_acc_op(op);

   // Direction of the pending fold; held until the next accumulate is taken
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sub_ff <= 1'b0;
      end else if (acc_take) begin
         sub_ff <= (op == op_multiply_subtract_signed)
                 | (op == op_multiply_subtract_unsigned);
      end
   end

   assign acc_now = {upper_acc_word_ff, bottom_acc_word_ff};

   // RQ17: 64-bit wrap, carry and borrow dropped
   assign nxt_acc = sub_ff ? (acc_now - prod_ff) : (acc_now + prod_ff);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_state_ff <= acc_idle;
      end else begin
         // A fold takes one cycle; no new take is accepted meanwhile
         unique case (acc_state_ff)
            acc_idle: begin
               if (acc_take) begin
                  acc_state_ff <= acc_run;
               end
            end
            acc_run: begin
               acc_state_ff <= acc_idle;
            end
         endcase
      end
   end

   // Words change only in the fold cycle, so early readers see the old pair
   // RQ10: bottom word 31..0, upper word 63..32
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         upper_acc_word_ff  <= ZERO32;
         bottom_acc_word_ff <= ZERO32;
      end else if (acc_state_ff == acc_run) begin
         upper_acc_word_ff  <= nxt_acc[ACC_W-1:DATA_W];
         bottom_acc_word_ff <= nxt_acc[DATA_W-1:0];
      end
   end

   // RQ11: busy is advisory, reads are never held off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_busy_ff <= 1'b0;
      end else begin
         acc_busy_ff <= acc_take;
      end
   end

   // Done marks the cycle in which the words show the new sum
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_done_ff <= 1'b0;
      end else begin
         acc_done_ff <= (acc_state_ff == acc_run);
      end
   end

   // New requests wait while an accumulator update is in flight
   // Ready low for one cycle keeps the fold and the next take apart
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         req_ready_ff <= 1'b0;
      end else begin
         req_ready_ff <= !acc_take;
      end
   end

endmodule

// >>> pkg/isa_ext_pkg.sv
package isa_ext_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ACC_W  = 64;
   localparam int unsigned REG_W  = 5;
   localparam int unsigned CNT_W  = 6;

   // Instruction field positions
   localparam int unsigned OPC_HI   = 31;
   localparam int unsigned OPC_LO   = 26;
   localparam int unsigned SRC_HI   = 25;
   localparam int unsigned SRC_LO   = 21;
   localparam int unsigned TST_HI   = 20;
   localparam int unsigned TST_LO   = 16;
   localparam int unsigned DST_HI   = 15;
   localparam int unsigned DST_LO   = 11;
   localparam int unsigned SHF_HI   = 10;
   localparam int unsigned SHF_LO   = 6;
   localparam int unsigned FUN_HI   = 5;
   localparam int unsigned FUN_LO   = 0;

   // Primary opcodes
   localparam logic [5:0] OPC_BASE_FUNC = 6'h00;
   localparam logic [5:0] OPC_GROUP28   = 6'h1C;

   // Function codes, base group
   localparam logic [5:0] FN_MOVE_IF_ZERO    = 6'h0A;
   localparam logic [5:0] FN_MOVE_IF_NONZERO = 6'h0B;

   // Function codes, function_group_twentyeight
   localparam logic [5:0] FN_MAC_SIGNED     = 6'h00;
   localparam logic [5:0] FN_MAC_UNSIGNED   = 6'h01;
   localparam logic [5:0] FN_THREE_OP_MUL   = 6'h02;
   localparam logic [5:0] FN_MULTIPLY_SUBTRACT_SIGNED_SIGNED    = 6'h04;
   localparam logic [5:0] FN_MULTIPLY_SUBTRACT_SIGNED_UNSIGNED  = 6'h05;
   localparam logic [5:0] FN_COUNT_ZEROS    = 6'h20;
   localparam logic [5:0] FN_COUNT_ONES     = 6'h21;

   // Assigned-encoding maps, one bit per code
   localparam logic [63:0] PRIMARY_MAP = 64'h070F_CF7F_10F7_FFFF;
   localparam logic [63:0] BASEFN_MAP  = 64'h005F_0CFF_0F0F_FFDD;
   localparam logic [63:0] GROUP28_MAP = 64'h0000_0003_0000_0037;

   localparam logic [4:0]        ZERO5  = 5'h00;
   localparam logic [9:0]        ZERO10 = 10'h000;
   localparam logic [DATA_W-1:0] ZERO32 = 32'h0000_0000;
   localparam logic [ACC_W-1:0]  ACC_RST = 64'h0000_0000_0000_0000;

   typedef enum logic [3:0] {
      op_none                         = 4'b0000,
      op_move_if_nonzero              = 4'b0001,
      op_move_if_zero                 = 4'b0010,
      op_multiply_accumulate_signed   = 4'b0011,
      op_multiply_accumulate_unsigned = 4'b0100,
      op_multiply_subtract_signed     = 4'b0101,
      op_multiply_subtract_unsigned   = 4'b0110,
      op_three_operand_multiply       = 4'b0111,
      op_count_leading_zero_bits      = 4'b1000,
      op_count_leading_one_bits       = 4'b1001,
      op_reserved                     = 4'b1010,
      op_wide                         = 4'b1011
   } ext_op_t;

   typedef enum logic [0:0] {
      acc_idle = 1'b0,
      acc_run  = 1'b1
   } acc_state_t;

   typedef struct packed {
      logic              valid;
      logic              wide_request;
      logic [DATA_W-1:0] instr;
      logic [DATA_W-1:0] operand_a_reg;
      logic [DATA_W-1:0] operand_b_reg;
   } ext_req_t;

   typedef struct packed {
      logic              valid;
      logic              claimed;
      logic              write;
      logic [REG_W-1:0]  dest;
      logic [DATA_W-1:0] data;
      logic              reserved_trap;
      logic              wide_trap;
   } ext_rsp_t;

endpackage

// >>> rtl/leading_bit_counter.sv
`timescale 1ns/1ps
module leading_bit_counter
   import isa_ext_pkg::*;
(
   input  wire logic [isa_ext_pkg::DATA_W-1:0] value,
   input  wire logic                           count_ones,
   output logic      [isa_ext_pkg::CNT_W-1:0]  count
);
   import isa_ext_pkg::*;

   logic [DATA_W:0] run;

   assign run[DATA_W] = 1'b1;

   // Bit i stays in the run only while every higher bit matched too
   genvar i;
   generate
      for (i = 0; i < DATA_W; i++) begin : g_run
         assign run[i] = run[i+1] & (value[i] == count_ones);
      end
   endgenerate

   // All-match gives 32, covering the all-clear and all-set cases
   always_comb begin
      count = '0;
      for (int k = 0; k < DATA_W; k++) begin
         count = count + CNT_W'(run[k]);
      end
   end
endmodule

// >>> verification/isa_ext_checker.sv
`timescale 1ns/1ps
module isa_ext_checker
   import isa_ext_pkg::*;
(
   input wire logic                           clk,
   input wire logic                           rstn,
   input wire isa_ext_pkg::ext_req_t          req,
   input wire logic                           req_ready_ff,
   input wire isa_ext_pkg::ext_rsp_t          rsp_ff,
   input wire logic [isa_ext_pkg::DATA_W-1:0] upper_acc_word_ff,
   input wire logic [isa_ext_pkg::DATA_W-1:0] bottom_acc_word_ff,
   input wire logic                           acc_busy_ff,
   input wire logic                           acc_done_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   function automatic logic [5:0] lead(input logic [31:0] v, input logic ones);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i] != ones) break;
         n = n + 6'h01;
      end
      return n;
   endfunction

   logic        take;
   logic        is_acc;
   logic        p_take_ff;
   ext_req_t    p_ff;
   logic        mvn_hit;
   logic        mvz_hit;
   logic        cnt_hit;
   logic [63:0] prod;
   logic [63:0] exp_acc_ff;
   assign take = req.valid && req_ready_ff;
   assign is_acc = take && !req.wide_request && req.instr[31:26] == OPC_GROUP28 &&
                   req.instr[15:6] == ZERO10 && req.instr[5:3] == 3'h0 && req.instr[1] == 1'b0;
   assign mvn_hit = p_take_ff && !p_ff.wide_request && p_ff.instr[31:26] == OPC_BASE_FUNC &&
                    p_ff.instr[10:6] == ZERO5 && p_ff.instr[5:0] == FN_MOVE_IF_NONZERO;
   assign mvz_hit = p_take_ff && !p_ff.wide_request && p_ff.instr[31:26] == OPC_BASE_FUNC &&
                    p_ff.instr[10:6] == ZERO5 && p_ff.instr[5:0] == FN_MOVE_IF_ZERO;
   assign cnt_hit = p_take_ff && !p_ff.wide_request && p_ff.instr[31:26] == OPC_GROUP28 &&
                    p_ff.instr[15:6] == ZERO10 && p_ff.instr[5:1] == 5'h10;
   // Sign or zero extension to 64 bits keeps to two unsigned multiplies for all four ops
   assign prod = req.instr[0] ?
                 {32'h0000_0000, req.operand_a_reg} * {32'h0000_0000, req.operand_b_reg} :
                 {{32{req.operand_a_reg[31]}}, req.operand_a_reg} *
                 {{32{req.operand_b_reg[31]}}, req.operand_b_reg};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         p_take_ff <= 1'b0;
         p_ff <= '0;
      end else begin
         p_take_ff <= take;
         p_ff <= req;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         exp_acc_ff <= ACC_RST;
      end else if (is_acc) begin
         exp_acc_ff <= req.instr[2] ? {upper_acc_word_ff, bottom_acc_word_ff} - prod :
                                      {upper_acc_word_ff, bottom_acc_word_ff} + prod;
      end
   end

   sequence acc_step;
      acc_busy_ff && !req_ready_ff ##1 acc_done_ff && req_ready_ff;
   endsequence

   resp_pulse_a: assert property (take |=> rsp_ff.valid)
      else $error("response missing after take");
   resp_idle_a: assert property (!take |=> !rsp_ff.valid)
      else $error("response without take");
   wide_trap_a: assert property (
      take && req.wide_request |=> rsp_ff.wide_trap && !rsp_ff.write)
      else $error("wide request not trapped");
   move_nonzero_a: assert property (
      mvn_hit |-> rsp_ff.write == (p_ff.operand_b_reg != ZERO32) &&
      (!rsp_ff.write || rsp_ff.data == p_ff.operand_a_reg && rsp_ff.dest == p_ff.instr[15:11]))
      else $error("move if nonzero wrong");
   move_zero_a: assert property (
      mvz_hit |-> rsp_ff.write == (p_ff.operand_b_reg == ZERO32) &&
      (!rsp_ff.write || rsp_ff.data == p_ff.operand_a_reg && rsp_ff.dest == p_ff.instr[15:11]))
      else $error("move if zero wrong");
   acc_timing_a: assert property (is_acc |=> acc_step)
      else $error("accumulate timing wrong");
   acc_value_a: assert property (
      acc_done_ff |-> {upper_acc_word_ff, bottom_acc_word_ff} == exp_acc_ff)
      else $error("accumulator value wrong");
   acc_hold_a: assert property (
      !acc_done_ff |-> $stable({upper_acc_word_ff, bottom_acc_word_ff}))
      else $error("accumulator changed without done");
   count_bits_a: assert property (
      cnt_hit |-> rsp_ff.write && rsp_ff.dest == p_ff.instr[20:16] &&
      rsp_ff.data == {26'h0, lead(p_ff.operand_a_reg, p_ff.instr[0])})
      else $error("leading count wrong");
endmodule

bind isa_extension_execute_unit isa_ext_checker i_isa_ext_checker (
   .clk                (clk),
   .rstn               (rstn),
   .req                (req),
   .req_ready_ff       (req_ready_ff),
   .rsp_ff             (rsp_ff),
   .upper_acc_word_ff  (upper_acc_word_ff),
   .bottom_acc_word_ff (bottom_acc_word_ff),
   .acc_busy_ff        (acc_busy_ff),
   .acc_done_ff        (acc_done_ff)
);

// >>> verification/pipeline_issuer.sv
`timescale 1ns/1ps
module pipeline_issuer
   import isa_ext_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  req_ready_ff,
   input  wire isa_ext_pkg::ext_rsp_t rsp_ff,
   output isa_ext_pkg::ext_req_t      req
);
   initial req = '0;

   // Drives on the falling edge, holds through the taking edge, collects the answer one cycle on
   task automatic issue(input logic [31:0] instr, input logic [31:0] a, input logic [31:0] b,
                        input logic wide, output ext_rsp_t r);
      int n;
      n = 0;
      @(negedge clk);
      while (req_ready_ff !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      req = {1'b1, wide, instr, a, b};
      @(negedge clk);
      r = rsp_ff;
      req.valid = 1'b0;
   endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
   import isa_ext_pkg::*;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   ext_req_t    req;
   logic        req_ready_ff;
   ext_rsp_t    rsp_ff;
   logic [31:0] upper_acc_word_ff;
   logic [31:0] bottom_acc_word_ff;
   logic        acc_busy_ff;
   logic        acc_done_ff;
   int          n_fail = 0;
   int          checks = 0;
   ext_rsp_t    r;

   isa_extension_execute_unit i_isa_extension_execute_unit (.clk(clk), .rstn(rstn), .req(req),
      .req_ready_ff(req_ready_ff), .rsp_ff(rsp_ff), .upper_acc_word_ff(upper_acc_word_ff),
      .bottom_acc_word_ff(bottom_acc_word_ff), .acc_busy_ff(acc_busy_ff),
      .acc_done_ff(acc_done_ff));
   pipeline_issuer i_pipeline_issuer (.clk(clk), .req_ready_ff(req_ready_ff), .rsp_ff(rsp_ff),
      .req(req));

   always #50 clk = ~clk;

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] ins(input logic [5:0] op, input logic [9:0] mid,
                                       input logic [5:0] fn);
      return {op, 5'h03, 5'h04, mid, fn};
   endfunction

   task automatic s_moves();
      logic [31:0] b;
      logic        w;
      for (int i = 0; i < 4; i++) begin
         b = i[0] ? 32'h0000_0000 : 32'h0000_0100;
         w = (i < 2) ? (b != 32'h0) : (b == 32'h0);
         i_pipeline_issuer.issue(ins(6'h00, 10'h120, (i < 2) ? 6'h0B : 6'h0A), 32'hCAFE_0001,
                                 b, 1'b0, r);
         chk("move_write", {63'h0, w}, {63'h0, r.write});
         chk("move_claim", 64'h1, {63'h0, r.claimed});
         if (w) chk("move_data", 64'hCAFE_0001, {32'h0, r.data});
         if (w) chk("move_dest", 64'h9, {59'h0, r.dest});
      end
   endtask

   task automatic s_acc();
      logic [31:0] av [4] = '{32'hFFFF_FFFD, 32'hFFFF_FFFF, 32'hFFFF_FFFD, 32'h8000_0000};
      logic [31:0] bv [4] = '{32'h0000_0005, 32'hFFFF_FFFF, 32'hFFFF_FFFD, 32'h0000_0002};
      logic [5:0]  fv [4] = '{6'h00, 6'h01, 6'h04, 6'h05};
      logic [63:0] acc;
      logic [63:0] p;
      acc = 64'h0;
      for (int i = 0; i < 4; i++) begin
         p = fv[i][0] ? {32'h0, av[i]} * {32'h0, bv[i]} :
                        {{32{av[i][31]}}, av[i]} * {{32{bv[i][31]}}, bv[i]};
         acc = fv[i][2] ? acc - p : acc + p;
         i_pipeline_issuer.issue(ins(6'h1C, 10'h000, fv[i]), av[i], bv[i], 1'b0, r);
         chk("acc_busy", 64'h1, {63'h0, acc_busy_ff});
         chk("acc_write", 64'h0, {63'h0, r.write});
         @(negedge clk);
         chk("acc_done", 64'h1, {63'h0, acc_done_ff});
         chk("acc_words", acc, {upper_acc_word_ff, bottom_acc_word_ff});
      end
   endtask

   task automatic s_counts();
      logic [31:0] v [6] = '{32'h0, 32'h1, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0, 32'hF000_0000};
      logic [5:0]  e [6] = '{6'd32, 6'd31, 6'd0, 6'd32, 6'd0, 6'd4};
      for (int i = 0; i < 6; i++) begin
         i_pipeline_issuer.issue(ins(6'h1C, 10'h000, (i < 3) ? 6'h20 : 6'h21), v[i], 32'h0,
                                 1'b0, r);
         chk("count_data", {58'h0, e[i]}, {32'h0, r.data});
         chk("count_dest", 64'h4, {59'h0, r.dest});
      end
   endtask

   task automatic s_mul3();
      i_pipeline_issuer.issue(ins(6'h1C, 10'h1C0, 6'h02), 32'hFFFF_FFF9, 32'h6, 1'b0, r);
      chk("mul_data", 64'hFFFF_FFD6, {32'h0, r.data});
      chk("mul_dest", 64'h2E, {58'h0, r.write, r.dest});
   endtask

   task automatic s_traps();
      logic [31:0] bad [4] = '{ins(6'h1C, 10'h000, 6'h03), ins(6'h1C, 10'h001, 6'h20),
                               ins(6'h13, 10'h000, 6'h00), ins(6'h00, 10'h121, 6'h0B)};
      i_pipeline_issuer.issue(ins(6'h00, 10'h120, 6'h0B), 32'h1, 32'h1, 1'b1, r);
      chk("wide_trap", 64'h2, {62'h0, r.wide_trap, r.write});
      // Assigned base op that the main pipeline runs: not claimed, no trap
      i_pipeline_issuer.issue(ins(6'h00, 10'h120, 6'h20), 32'h1, 32'h1, 1'b0, r);
      chk("base_claim", 64'h0, {61'h0, r.claimed, r.reserved_trap, r.write});
      for (int i = 0; i < 4; i++) begin
         i_pipeline_issuer.issue(bad[i], 32'h1, 32'h1, 1'b0, r);
         chk("reserved_trap", 64'h2, {62'h0, r.reserved_trap, r.write});
      end
   endtask

   task automatic finish_test();
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #(100 * 2000);
      n_fail++;
      finish_test();
   end

   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      chk("acc_reset", 64'h0, {upper_acc_word_ff, bottom_acc_word_ff});
      s_moves();
      s_acc();
      s_counts();
      s_mul3();
      s_traps();
      finish_test();
   end
endmodule
